// ---- logic/plate_motion_monitor.sv ----
// Module: plate motion fault monitor
//
// Contract
// - Fault if home sensor not active after 0.3 s of drive.
// - Fault if home sensor not inactive after 80 ms of drive.
// - Fault if lead-edge sensor not inactive after 80 ms of drive.
// - Fault if lead-edge sensor not active after 0.3 s of drive.
// - Count motor pulses per drive; fault when count below expected.
// - All failures share one readable fault code.
// - Fault stays latched until rstn goes low.
`timescale 1ns/1ps
module plate_motion_monitor #(
   parameter int REACH_CYC = plate_fault_pkg::REACH_CYCLES,
   parameter int LEAVE_CYC = plate_fault_pkg::LEAVE_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic plate_drive_motor,
   input wire logic plate_home_sensor,
   input wire logic plate_lead_edge_sensor,
   input wire logic plate_motor_pulse_sensor,
   input wire logic [15:0] expected_pulses,
   output logic plate_fault,
   output logic [23:0] fault_code,
   output logic [2:0] fault_cause
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   plate_fault_pkg::mon_s q;
   plate_fault_pkg::mon_s d;
   logic [plate_fault_pkg::TMR_W-1:0] reach_lim;
   logic [plate_fault_pkg::TMR_W-1:0] leave_lim;
   logic short_count;
   logic in_drive;
   logic at_leave;
   logic at_reach;

   assign reach_lim = plate_fault_pkg::TMR_W'(REACH_CYC);
   assign leave_lim = plate_fault_pkg::TMR_W'(LEAVE_CYC);
   assign short_count = q.pulses < expected_pulses;

   // ------------------------------------------------------------
   // Deadline decode
   // ------------------------------------------------------------
   assign in_drive = q.st == plate_fault_pkg::ST_DRIVE;
   assign at_leave = in_drive && q.timer == leave_lim;
   assign at_reach = in_drive && q.timer == reach_lim;

   // ------------------------------------------------------------
   // Saturating counters
   // ------------------------------------------------------------
   function automatic logic [plate_fault_pkg::TMR_W-1:0] timer_next(
      input logic [plate_fault_pkg::TMR_W-1:0] v
   );
      timer_next = (v == '1) ? v : v + 1'b1;
   endfunction : timer_next

   function automatic logic [plate_fault_pkg::CNT_W-1:0] count_next(
      input logic [plate_fault_pkg::CNT_W-1:0] v
   );
      count_next = (v == '1) ? v : v + 1'b1;
   endfunction : count_next

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      d = q;
      d.s1.home = plate_home_sensor;
      d.s1.lead = plate_lead_edge_sensor;
      d.s1.pulse = plate_motor_pulse_sensor;
      d.s2 = q.s1;
      d.pulse_prev = q.s2.pulse;
      case (q.st)
         plate_fault_pkg::ST_IDLE: begin
            d.timer = '0;
            d.pulses = '0;
            d.home_on = 1'b0;
            d.home_off = 1'b0;
            d.lead_on = 1'b0;
            d.lead_off = 1'b0;
            if (plate_drive_motor) begin
               d.st = plate_fault_pkg::ST_DRIVE;
            end
         end
         plate_fault_pkg::ST_DRIVE: begin
            d.timer = timer_next(q.timer);
            if (q.s2.pulse && !q.pulse_prev) begin
               d.pulses = count_next(q.pulses);
            end
            // Turning on counts only after the sensor was seen off
            if (q.s2.home && q.home_off) d.home_on = 1'b1;
            if (!q.s2.home) d.home_off = 1'b1;
            if (q.s2.lead && q.lead_off) d.lead_on = 1'b1;
            if (!q.s2.lead) d.lead_off = 1'b1;
            if (at_leave && !q.home_off && q.s2.home) begin
               d.fault = 1'b1;
               d.cause = 3'h2;
            end else if (at_leave && !q.lead_off && q.s2.lead) begin
               d.fault = 1'b1;
               d.cause = 3'h3;
            end else if (at_reach && !q.home_on && !q.s2.home) begin
               d.fault = 1'b1;
               d.cause = 3'h1;
            end else if (at_reach && !q.lead_on && !q.s2.lead) begin
               d.fault = 1'b1;
               d.cause = 3'h4;
            end else if (!plate_drive_motor && short_count) begin
               d.fault = 1'b1;
               d.cause = 3'h5;
            end
            if (d.fault) begin
               d.st = plate_fault_pkg::ST_FAULT;
            end else if (!plate_drive_motor) begin
               d.st = plate_fault_pkg::ST_IDLE;
            end
         end
         plate_fault_pkg::ST_FAULT: begin
            d.st = plate_fault_pkg::ST_FAULT;
         end
         default: begin
            d.st = plate_fault_pkg::ST_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign plate_fault = q.fault;
   assign fault_cause = q.cause;
   assign fault_code = q.fault ? {plate_fault_pkg::CODE_MAJOR,
      plate_fault_pkg::CODE_MID, plate_fault_pkg::CODE_MINOR}
      : plate_fault_pkg::CODE_NONE;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_fault_sticky: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      q.fault |=> q.fault)
      else $error("fault cleared");

   a_cause_kept: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      q.fault |=> $stable(q.cause))
      else $error("fault cause changed");

   a_state_locked: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      (q.st == plate_fault_pkg::ST_FAULT) |=>
      (q.st == plate_fault_pkg::ST_FAULT))
      else $error("fault state left");

   a_code_shared: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      q.fault |-> fault_code == 24'h420C2D)
      else $error("bad code");

   a_code_clear: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      !q.fault |-> fault_code == 24'h000000)
      else $error("code without fault");

   a_cause_known: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      q.fault |-> (q.cause >= 3'h1 && q.cause <= 3'h5))
      else $error("unknown cause");

   a_home_leave: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      (at_leave && !q.home_off && q.s2.home) |=>
      (q.fault && q.cause == 3'h2))
      else $error("home leave missed");

   a_lead_leave: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      (at_leave && q.home_off && !q.lead_off && q.s2.lead) |=>
      (q.fault && q.cause == 3'h3))
      else $error("lead leave missed");

   a_home_reach: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      (at_reach && !q.home_on && !q.s2.home) |=> q.fault)
      else $error("home reach missed");

   a_lead_reach: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      (at_reach && !at_leave && q.home_on && !q.lead_on && !q.s2.lead)
      |=> (q.fault && q.cause == 3'h4))
      else $error("lead reach missed");

   a_pulse_short: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      (in_drive && !plate_drive_motor && short_count) |=> q.fault)
      else $error("short count missed");

   a_pulse_count: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      (in_drive && q.s2.pulse && !q.pulse_prev && q.pulses != '1) |=>
      (q.pulses == $past(q.pulses) + 1'b1))
      else $error("pulse not counted");

   a_idle_reset: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      (q.st == plate_fault_pkg::ST_IDLE) |=>
      (q.timer == '0 && q.pulses == '0))
      else $error("timer not restarted");

   a_timer_runs: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      (in_drive && q.timer != '1) |=>
      (q.timer == $past(q.timer) + 1'b1))
      else $error("timer stalled");

   a_new_drive: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      (q.st == plate_fault_pkg::ST_IDLE && plate_drive_motor) |=>
      (in_drive && q.timer == '0 && q.pulses == '0))
      else $error("drive not started");

   a_drive_stop: assert property (
      @(posedge ref_clk) disable iff (!rstn)
      (in_drive && !plate_drive_motor && !short_count && !at_leave
       && !at_reach) |=> (q.st == plate_fault_pkg::ST_IDLE))
      else $error("drive not stopped");

endmodule : plate_motion_monitor

// ---- logic/plate_fault_pkg.sv ----
// Package: constants and types for the plate motion fault monitor
package plate_fault_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int REACH_TIME_MS = 300;
   localparam int LEAVE_TIME_MS = 80;
   localparam int REACH_CYCLES = CLK_HZ / 1000 * REACH_TIME_MS;
   localparam int LEAVE_CYCLES = CLK_HZ / 1000 * LEAVE_TIME_MS;
   localparam int TMR_W = 24;
   localparam int CNT_W = 16;

   // ------------------------------------------------------------
   // Fault code and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] CODE_MAJOR = 8'h42;
   localparam logic [7:0] CODE_MID = 8'h0C;
   localparam logic [7:0] CODE_MINOR = 8'h2D;
   localparam logic [23:0] CODE_NONE = 24'h000000;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DRIVE = 2'b01,
      ST_FAULT = 2'b10
   } mon_state_e;

   typedef struct packed {
      logic home;
      logic lead;
      logic pulse;
   } sensors_s;

   typedef struct packed {
      mon_state_e st;
      sensors_s s1;
      sensors_s s2;
      logic pulse_prev;
      logic [TMR_W-1:0] timer;
      logic [CNT_W-1:0] pulses;
      logic home_on;
      logic home_off;
      logic lead_on;
      logic lead_off;
      logic fault;
      logic [2:0] cause;
   } mon_s;

endpackage : plate_fault_pkg

// ---- verification/plate_mech_model.sv ----
// Model of the plate drive motor and its optical position sensors
`timescale 1ns/1ps
module plate_mech_model (
   input wire logic ref_clk,
   input wire logic plate_drive_motor,
   input wire logic [2:0] mode,
   output logic home,
   output logic lead,
   output logic pulse
);
   // ------------------------------------------------------------
   // Motion: plate leaves home after 3 cycles, is back by cycle 20
   // ------------------------------------------------------------
   int t = 0;
   logic away;
   always @(posedge ref_clk) begin
      t <= plate_drive_motor ? t + 1 : 0;
   end
   always_comb begin
      away = t >= 3 && t < 20;
      home = mode == 3'h1 ? 1'b0 : mode == 3'h2 ? 1'b1 : !away;
      lead = mode == 3'h4 ? 1'b0 : mode == 3'h3 ? 1'b1 : !away;
      // Pulse train only while the motor turns; mode 5 is a dead encoder
      pulse = mode != 3'h5 && plate_drive_motor && t[1];
   end
endmodule : plate_mech_model

// ---- verification/testbench.sv ----
// Self-checking bench for the plate motion fault monitor
`timescale 1ns/1ps
module testbench;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic drive = 1'b0;
   logic [2:0] mode = 3'h0;
   logic [15:0] exp_pulses = 16'h000A;
   logic home, lead, pulse, plate_fault;
   logic [23:0] fault_code;
   logic [2:0] fault_cause;
   int fails = 0;
   int checks_done = 0;
   initial forever #25 ref_clk = ~ref_clk;
   plate_mech_model u_plate_mech_model (.ref_clk(ref_clk),
      .plate_drive_motor(drive), .mode(mode), .home(home), .lead(lead),
      .pulse(pulse));
   plate_motion_monitor #(.REACH_CYC(40), .LEAVE_CYC(10))
      u_plate_motion_monitor (.ref_clk(ref_clk), .rstn(rstn),
      .plate_drive_motor(drive), .plate_home_sensor(home),
      .plate_lead_edge_sensor(lead), .plate_motor_pulse_sensor(pulse),
      .expected_pulses(exp_pulses), .plate_fault(plate_fault),
      .fault_code(fault_code), .fault_cause(fault_cause));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic check(string name, logic [23:0] seen, logic [23:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : finish_test
   task automatic do_reset();
      rstn <= 1'b0;
      repeat (20) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
   endtask : do_reset
   task automatic run_drive(int len);
      drive <= 1'b1;
      repeat (len) @(posedge ref_clk);
      drive <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask : run_drive
   task automatic expect_clear();
      check("fault", {23'h0, plate_fault}, 24'h0);
      check("code", fault_code, 24'h0);
      check("cause", {21'h0, fault_cause}, 24'h0);
   endtask : expect_clear
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic good_back_to_back();
      mode <= 3'h0;
      run_drive(50);
      run_drive(50);
      expect_clear();
   endtask : good_back_to_back
   task automatic fault_case(logic [2:0] m, logic [2:0] cause);
      int n;
      do_reset();
      mode <= m;
      // Let the forced sensor level pass the synchroniser first
      repeat (4) @(posedge ref_clk);
      drive <= 1'b1;
      for (n = 0; n < 120 && plate_fault !== 1'b1; n++) begin
         if (n == 50) drive <= 1'b0;
         @(posedge ref_clk);
      end
      drive <= 1'b0;
      @(posedge ref_clk);
      if (n == 120) begin
         fails++;
         finish_test();
      end
      check("code", fault_code, 24'h420C2D);
      check("cause", {21'h0, fault_cause}, {21'h0, cause});
      // Fault must survive a clean drive afterwards
      mode <= 3'h0;
      run_drive(50);
      check("latched", {23'h0, plate_fault}, 24'h1);
      check("cause kept", {21'h0, fault_cause}, {21'h0, cause});
   endtask : fault_case
   task automatic pulse_threshold();
      do_reset();
      mode <= 3'h0;
      // A clean drive of 50 cycles yields 12 pulse edges
      exp_pulses <= 16'h000C;
      run_drive(50);
      check("at limit", {23'h0, plate_fault}, 24'h0);
      exp_pulses <= 16'h000D;
      run_drive(50);
      check("below limit", {23'h0, plate_fault}, 24'h1);
      check("short cause", {21'h0, fault_cause}, 24'h5);
      exp_pulses <= 16'h000A;
   endtask : pulse_threshold
   initial begin
      do_reset();
      expect_clear();
      good_back_to_back();
      pulse_threshold();
      for (int c = 1; c <= 5; c++) begin
         fault_case(c[2:0], c[2:0]);
      end
      do_reset();
      expect_clear();
      finish_test();
   end
endmodule : testbench
